// ==== rtl/iep_pkg.sv ====
// Shared constants and carriers of the interrupt enable, priority and wake
// block. Assumes an 8-bit special-function register port from the core.
package iep_pkg;
  // Register offsets on the special-function register port.
  localparam logic [7:0] A_TPFC = 8'h88;
  localparam logic [7:0] A_EXFS = 8'h91;
  localparam logic [7:0] A_WKM = 8'h9f;
  localparam logic [7:0] A_BEN = 8'ha8;
  localparam logic [7:0] A_BPS = 8'hb8;
  localparam logic [7:0] A_EES = 8'he8;
  localparam logic [7:0] A_EPS = 8'hf8;
  // Reset values.
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [7:0] R_WKM = 8'hff;
  // Field positions.
  localparam int B_TF1 = 7;
  localparam int B_TF0 = 5;
  localparam int B_P1F = 3;
  localparam int B_P0F = 1;
  localparam int B_GATE = 7;
  localparam int B_TWM = 0;
  localparam int B_BPS_HI = 6;
  // Source numbering in natural order, lowest first.
  localparam int NSRC = 15;
  localparam logic [4:0] V_PIN0 = 5'h00;
  localparam logic [4:0] V_TMR0 = 5'h01;
  localparam logic [4:0] V_PIN1 = 5'h02;
  localparam logic [4:0] V_TMR1 = 5'h03;
  localparam logic [4:0] V_BKP = 5'h10;
  localparam logic [4:0] V_DBG = 5'h11;
  // Wake lines that can run without the system clock (8,7,3,pin1,pin0).
  localparam logic [7:0] WAKE_OK = 8'hcb;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iep_sfr_s;

  // Flags held inside the grouped peripherals, one per live line.
  typedef struct packed {
    logic tmr_buzz;
    logic spi_slave;
    logic pwm_grp;
    logic touch;
    logic lvd;
  } iep_ext_s;
endpackage

// ==== rtl/iep_edge.sv ====
// Rising and falling edge detector over a vector of levels.
// Assumes the levels are synchronous to clk.
`timescale 1ns/100ps
module iep_edge #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev;

  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

// ==== rtl/iep_wake.sv ====
// Wake-up decision from per-line edge events while the core is stopped.
// Assumes line events are one-cycle pulses from edge detectors.
`timescale 1ns/100ps
module iep_wake #(
  parameter logic [7:0] OK_MASK = iep_pkg::WAKE_OK
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic stop_mode,
  input wire logic osc_running,
  input wire logic [7:0] line_evt,
  input wire logic [7:0] mask,
  output logic wake,
  output logic restore
);
  logic hit;

  // Enables play no part here; the core resumes even with no handler.
  // Sampled here; silicon latches the edge with the system clock stopped.
  assign hit = stop_mode && (|(line_evt & mask & OK_MASK)); // RQ12 RQ13 RQ15

  always_ff @(posedge clk) begin
    if (srst) begin
      wake <= 1'b0;
      restore <= 1'b0;
    end else begin
      wake <= hit; // RQ11
      restore <= hit && osc_running; // RQ14
    end
  end

  a_wake_edge: assert property (@(posedge clk) disable iff (srst)
    hit |=> wake) else $error("wake missed"); // RQ12
  a_wake_gated: assert property (@(posedge clk) disable iff (srst)
    wake |-> $past(stop_mode)) else $error("wake outside stop"); // RQ15
  a_clk_restore: assert property (@(posedge clk) disable iff (srst)
    restore |-> wake && $past(osc_running)) else $error("bad restore"); // RQ14
  c_wake: cover property (@(posedge clk) disable iff (srst) restore);
endmodule

// ==== rtl/iep_top.sv ====
// Interrupt enables, two-level priority, flag collection and wake masking.
// Assumes the core reads and writes registers on the sfr port and pulses
// irq_ack when it enters the routine named by irq_vec.
//
// Functional notes
// (RQ1) Global gate clear blocks every maskable request regardless of enables.
// (RQ2) Extended enable register resets to zero, bits for grouped lines.
// (RQ3) One priority bit per source; one means high level.
// (RQ4) Basic priority register holds seven bits, bit 7 unused, resets zero.
// (RQ5) Extended priority register mirrors extended enable bit order, resets zero.
// (RQ6) Grouped lines map fixed peripheral groups; line four is reserved.
// (RQ7) Extended flags of lines two to eight mirror peripherals; unwritable.
// (RQ8) Two-wire master flag is set by hardware, cleared by software write.
// (RQ9) Timer overflow flags clear on routine entry; software cannot write them.
// (RQ10) Pin line flags clear on routine entry and are also writable.
// (RQ11) Wake mask resets to all ones; set bit lets a line wake.
// (RQ12) Wake-up reacts to edges even for level-triggered interrupts.
// (RQ13) Wake path ignores enables; core may resume without a routine.
// (RQ14) Valid wake restores the system clock if the oscillator runs.
// (RQ15) Only clockless or slow-clock sources can wake the device.
// (RQ16) Each pin feeds pin line zero or one, with selectable edges.
// (RQ17) Requests sampled on rising clock; highest pending enabled one vectored.
// (RQ18) High level served first; ties broken by lower natural number.
// (RQ19) Software writes can only clear flags, never set them.
// (RQ20) Debug beats breakpoint beats all; global gate does not block them.
// (RQ21) Winning vector is held until the core acknowledges entry.
// (RQ22) Wake mask writes take effect only while protect_open is high.
`timescale 1ns/100ps
module iep_top #(
  parameter int NPIN = 8,
  parameter logic [7:0] WAKE_OK_MASK = iep_pkg::WAKE_OK
) (
  input wire logic clk,
  input wire logic srst,
  input wire iep_pkg::iep_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  input wire logic protect_open,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic uart0_flag,
  input wire logic tmr2_flag,
  input wire logic uart2_flag,
  input wire logic wdog_flag,
  input wire logic twm_set,
  input wire iep_pkg::iep_ext_s ext_flag,
  input wire logic [NPIN-1:0] gpio_in,
  input wire logic [NPIN-1:0] pin_sel_one,
  input wire logic [NPIN-1:0] pin_rise_en,
  input wire logic [NPIN-1:0] pin_fall_en,
  input wire logic dbg_req,
  input wire logic bkp_req,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [4:0] irq_vec,
  input wire logic stop_mode,
  input wire logic osc_running,
  output logic wake,
  output logic clk_restore
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int NSRC_W = iep_pkg::NSRC;

  logic [7:0] ben;
  logic [7:0] bps;
  logic [7:0] ees;
  logic [7:0] eps;
  logic [7:0] wkm;
  logic tf0;
  logic tf1;
  logic p0f;
  logic p1f;
  logic twm_flag;
  logic [7:0] exf_view;
  logic [7:0] tpf_view;
  logic [NPIN-1:0] pin_r;
  logic [NPIN-1:0] pin_f;
  logic [NPIN-1:0] pin_evt;
  logic pin0_evt;
  logic pin1_evt;
  logic [4:0] ext_lvl;
  logic [4:0] ext_r;
  logic [7:0] wake_evt;
  logic [NSRC_W-1:0] flags;
  logic [NSRC_W-1:0] enab;
  logic [NSRC_W-1:0] prio;
  logic [NSRC_W-1:0] pend;
  logic [NSRC_W-1:0] pend_hi;
  logic [4:0] next_vec;
  logic next_req;
  logic wr_tpf;
  logic wr_exf;
  logic entry;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detection and line routing.
  iep_edge #(.W(NPIN)) u_pin_edge (
    .clk(clk),
    .srst(srst),
    .level(gpio_in),
    .rise(pin_r),
    .fall(pin_f)
  );

  assign pin_evt = (pin_r & pin_rise_en) | (pin_f & pin_fall_en); // RQ16
  assign pin1_evt = |(pin_evt & pin_sel_one); // RQ16
  assign pin0_evt = |(pin_evt & ~pin_sel_one); // RQ16

  // Grouped lines: lvd=2, touch=3, pwm=6, spi=7, timers/buzzer=8.
  assign ext_lvl = {ext_flag.tmr_buzz, ext_flag.spi_slave, ext_flag.pwm_grp,
                    ext_flag.touch, ext_flag.lvd}; // RQ6

  iep_edge #(.W(5)) u_ext_edge (
    .clk(clk),
    .srst(srst),
    .level(ext_lvl),
    .rise(ext_r),
    .fall()
  );

  // Line four is reserved and never wakes.
  assign wake_evt = {ext_r[4:2], 1'b0, ext_r[1:0], pin1_evt, pin0_evt}; // RQ12

  iep_wake #(.OK_MASK(WAKE_OK_MASK)) u_wake (
    .clk(clk),
    .srst(srst),
    .stop_mode(stop_mode),
    .osc_running(osc_running),
    .line_evt(wake_evt),
    .mask(wkm),
    .wake(wake),
    .restore(clk_restore)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      ben <= iep_pkg::R_ZERO;
      bps <= iep_pkg::R_ZERO;
      ees <= iep_pkg::R_ZERO; // RQ2
      eps <= iep_pkg::R_ZERO; // RQ5
    end else if (sfr.wr) begin
      if (sfr.addr == iep_pkg::A_BEN) begin
        ben <= sfr.wdata;
      end
      if (sfr.addr == iep_pkg::A_BPS) begin
        bps <= {1'b0, sfr.wdata[iep_pkg::B_BPS_HI:0]}; // RQ4
      end
      if (sfr.addr == iep_pkg::A_EES) begin
        ees <= sfr.wdata; // RQ2
      end
      if (sfr.addr == iep_pkg::A_EPS) begin
        eps <= sfr.wdata; // RQ5
      end
    end
  end

  // The mask guards sleep exit, so a stray write must not unlock it.
  always_ff @(posedge clk) begin
    if (srst) begin
      wkm <= iep_pkg::R_WKM; // RQ11
    end else if (sfr.wr && sfr.addr == iep_pkg::A_WKM && protect_open) begin
      wkm <= sfr.wdata; // RQ22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags held here. A hardware set wins over any clear in the same cycle.
  assign wr_tpf = sfr.wr && sfr.addr == iep_pkg::A_TPFC;
  assign wr_exf = sfr.wr && sfr.addr == iep_pkg::A_EXFS;
  assign entry = irq_req && irq_ack;

  always_ff @(posedge clk) begin
    if (srst) begin
      tf0 <= 1'b0;
      tf1 <= 1'b0;
    end else begin
      // Not writable: only routine entry clears these.
      tf0 <= tmr0_ovf
             || (tf0 && !(entry && irq_vec == iep_pkg::V_TMR0)); // RQ9
      tf1 <= tmr1_ovf
             || (tf1 && !(entry && irq_vec == iep_pkg::V_TMR1)); // RQ9
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p0f <= 1'b0;
      p1f <= 1'b0;
    end else begin
      // Writing zero clears; writing one leaves the flag alone.
      p0f <= pin0_evt || (p0f && !(entry && irq_vec == iep_pkg::V_PIN0)
             && !(wr_tpf && !sfr.wdata[iep_pkg::B_P0F])); // RQ10 RQ19
      p1f <= pin1_evt || (p1f && !(entry && irq_vec == iep_pkg::V_PIN1)
             && !(wr_tpf && !sfr.wdata[iep_pkg::B_P1F])); // RQ10 RQ19
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      twm_flag <= 1'b0;
    end else begin
      twm_flag <= twm_set
                  || (twm_flag && !(wr_exf && !sfr.wdata[iep_pkg::B_TWM])); // RQ8
    end
  end

  // Bit 4 is unused and bit 3 belongs to the reserved line four.
  assign exf_view = {ext_lvl[4:2], 2'b00, ext_lvl[1:0], twm_flag}; // RQ7
  assign tpf_view = {tf1, 1'b0, tf0, 1'b0, p1f, 1'b0, p0f, 1'b0};

  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= iep_pkg::R_ZERO;
    end else if (sfr.rd) begin
      unique case (sfr.addr)
        iep_pkg::A_TPFC: sfr_rdata <= tpf_view;
        iep_pkg::A_EXFS: sfr_rdata <= exf_view;
        iep_pkg::A_WKM: sfr_rdata <= wkm;
        iep_pkg::A_BEN: sfr_rdata <= ben;
        iep_pkg::A_BPS: sfr_rdata <= bps;
        iep_pkg::A_EES: sfr_rdata <= ees;
        iep_pkg::A_EPS: sfr_rdata <= eps;
        default: sfr_rdata <= iep_pkg::R_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration. Index order is the natural order; enable and priority
  // vectors line up as {extended, basic[6:0]}.
  assign flags = {exf_view[7:5], wdog_flag, exf_view[3:0], uart2_flag,
                  tmr2_flag, uart0_flag, tf1, p1f, tf0, p0f};
  assign enab = {ees, ben[6:0]};
  assign prio = {eps, bps[6:0]}; // RQ3
  assign pend = flags & enab & {NSRC_W{ben[iep_pkg::B_GATE]}}; // RQ1
  assign pend_hi = pend & prio; // RQ18

  always_comb begin
    next_req = 1'b1;
    next_vec = 5'h00;
    if (dbg_req) begin
      next_vec = iep_pkg::V_DBG; // RQ20
    end else if (bkp_req) begin
      next_vec = iep_pkg::V_BKP; // RQ20
    end else if (|pend_hi) begin
      for (int i = NSRC_W - 1; i >= 0; i--) begin
        if (pend_hi[i]) begin
          next_vec = 5'(i); // RQ18
        end
      end
    end else if (|pend) begin
      for (int i = NSRC_W - 1; i >= 0; i--) begin
        if (pend[i]) begin
          next_vec = 5'(i); // RQ18
        end
      end
    end else begin
      next_req = 1'b0;
    end
  end

  // A taken vector stays put until entry, even if a better one arrives.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_req <= 1'b0;
      irq_vec <= 5'h00;
    end else if (!irq_req) begin
      irq_req <= next_req; // RQ17
      irq_vec <= next_vec; // RQ17
    end else if (irq_ack) begin
      irq_req <= 1'b0; // RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_gate_blocks: assert property (!irq_req && !ben[iep_pkg::B_GATE]
    && !dbg_req && !bkp_req |=> !irq_req)
    else $error("request passed closed gate"); // RQ1
  a_reset_vals: assert property (disable iff (1'b0) srst |=> ees == 8'h00
    && eps == 8'h00 && bps == 8'h00 && wkm == 8'hff)
    else $error("bad reset value"); // RQ2
  a_vec_held: assert property (irq_req && !irq_ack |=> irq_req
    && $stable(irq_vec)) else $error("vector moved before entry"); // RQ21
  a_high_first: assert property (!irq_req && |pend_hi && !dbg_req
    && !bkp_req |=> irq_req && prio[irq_vec[3:0]] && !irq_vec[4])
    else $error("low level beat high level"); // RQ18
  a_debug_top: assert property (!irq_req && dbg_req |=> irq_req
    && irq_vec == 5'h11) else $error("debug not first"); // RQ20
  a_tmr_clear: assert property (entry && irq_vec == 5'h01 && !tmr0_ovf
    |=> !tf0) else $error("timer flag not cleared"); // RQ9
  a_no_sw_set: assert property (wr_exf && !twm_flag && !twm_set
    |=> !twm_flag) else $error("software set a flag"); // RQ19
  a_mask_guard: assert property (sfr.wr && sfr.addr == 8'h9f
    && !protect_open |=> $stable(wkm)) else $error("unguarded mask"); // RQ22
  a_pin_flag: assert property (pin0_evt |=> p0f)
    else $error("pin line zero event lost"); // RQ16

  c_high_served: cover property (irq_req && prio[irq_vec[3:0]] && irq_ack);
  c_debug: cover property (irq_req && irq_vec == 5'h11);
  c_two_level: cover property (|pend_hi && (pend & ~prio) != '0);
endmodule

// ==== verification/iep_core_model.sv ====
// Core model: takes each held request and acknowledges it after a delay.
// Assumes irq_req and irq_vec are registered on the rising clock edge.
`timescale 1ns/100ps
module iep_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic [3:0] ack_dly,
  output logic irq_ack
);
  logic [3:0] cnt;

  // A long delay shows that the held vector is not preempted meanwhile.
  always_ff @(posedge clk) begin
    if (srst || !irq_req || irq_ack) begin
      cnt <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      irq_ack <= (cnt >= ack_dly);
    end
  end
endmodule

// ==== verification/iep_top_tb.sv ====
// Self-checking bench of the interrupt enable, priority and wake block.
// Assumes the core model acks requests; peripheral flags are driven here.
`timescale 1ns/100ps
module iep_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  iep_pkg::iep_sfr_s sfr = '0;
  iep_pkg::iep_ext_s ext_flag = '0;
  logic protect_open = 1'b0, tmr0_ovf = 1'b0, tmr1_ovf = 1'b0;
  logic twm_set = 1'b0, uart0_flag = 1'b0, tmr2_flag = 1'b0;
  logic uart2_flag = 1'b0, wdog_flag = 1'b0, dbg_req = 1'b0;
  logic bkp_req = 1'b0, stop_mode = 1'b0, osc_running = 1'b0;
  logic [7:0] gpio_in = '0, pin_sel_one = '0;
  logic [7:0] pin_rise_en = '0, pin_fall_en = '0;
  logic [7:0] sfr_rdata, r, e;
  logic irq_ack, irq_req, wake, clk_restore, rd_q;
  logic [4:0] irq_vec;
  logic [3:0] ack_dly = 4'h0;
  logic [15:0] lfsr = 16'h2237;
  logic [7:0] exp_rd[$], exp_vec[$], exp_wk[$];
  int n_fail = 0, num_checks = 0;

  always #20 clk = ~clk;

  iep_top u_dut (.clk, .srst, .sfr, .sfr_rdata, .protect_open, .tmr0_ovf,
    .tmr1_ovf, .uart0_flag, .tmr2_flag, .uart2_flag, .wdog_flag, .twm_set,
    .ext_flag, .gpio_in, .pin_sel_one, .pin_rise_en, .pin_fall_en, .dbg_req,
    .bkp_req, .irq_ack, .irq_req, .irq_vec, .stop_mode, .osc_running, .wake,
    .clk_restore);
  iep_core_model u_core (.clk, .srst, .irq_req, .ack_dly, .irq_ack);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    sfr <= '{1'b1, 1'b0, a, 8'h00};
    exp_rd.push_back(x);
    @(posedge clk);
    sfr.rd <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    {twm_set, tmr1_ovf, tmr0_ovf} <= p;
    @(posedge clk);
    {twm_set, tmr1_ovf, tmr0_ovf} <= 3'b000;
  endtask

  // The queue only empties when the core model has taken every vector.
  task automatic drain();
    int k;
    k = 0;
    while (exp_vec.size() != 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    check(8'(exp_vec.size()), 8'h00, "vectors left");
  endtask

  task automatic wait_req(input logic v);
    do @(posedge clk); while (irq_req !== v);
  endtask

  task automatic wk(input logic [7:0] g, input logic [4:0] x, input logic w);
    if (w) exp_wk.push_back({7'h0, osc_running});
    @(posedge clk);
    gpio_in <= g;
    ext_flag <= x;
    repeat (5) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) rd_q <= sfr.rd;

  always @(negedge clk) begin
    if (rd_q && !srst)
      check(sfr_rdata, exp_rd.size() ? exp_rd.pop_front() : 8'hee, "rdata");
    if (irq_req && irq_ack)
      check({3'h0, irq_vec}, exp_vec.size() ? exp_vec.pop_front() : 8'hee, "vec");
    if (wake)
      check({7'h0, clk_restore}, exp_wk.size() ? exp_wk.pop_front() : 8'hee, "wake");
  end

  initial begin
    #(40 * 4000);
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(iep_pkg::A_TPFC, iep_pkg::R_ZERO);
    rd(iep_pkg::A_EXFS, iep_pkg::R_ZERO);
    rd(iep_pkg::A_WKM, iep_pkg::R_WKM);
    rd(iep_pkg::A_BPS, iep_pkg::R_ZERO);
    rd(iep_pkg::A_EES, iep_pkg::R_ZERO);
    rd(iep_pkg::A_EPS, iep_pkg::R_ZERO);
    rd(8'h00, 8'h00);
    $display("test reset values done");
    r = rnd();
    wr(iep_pkg::A_BPS, 8'hff);
    rd(iep_pkg::A_BPS, 8'h7f);
    wr(iep_pkg::A_EES, r);
    rd(iep_pkg::A_EES, r);
    wr(iep_pkg::A_EPS, ~r);
    rd(iep_pkg::A_EPS, ~r);
    wr(iep_pkg::A_WKM, 8'h00);
    rd(iep_pkg::A_WKM, iep_pkg::R_WKM);
    protect_open <= 1'b1;
    wr(iep_pkg::A_WKM, r);
    rd(iep_pkg::A_WKM, r);
    wr(iep_pkg::A_EES, 8'h00);
    wr(iep_pkg::A_EPS, 8'h00);
    wr(iep_pkg::A_BPS, 8'h00);
    $display("test register access done");
    r = rnd();
    pulse(3'b101);
    ext_flag <= r[4:0];
    wr(iep_pkg::A_TPFC, 8'h00);
    rd(iep_pkg::A_TPFC, 8'h20);
    wr(iep_pkg::A_TPFC, 8'h0a);
    rd(iep_pkg::A_TPFC, 8'h20);
    e = {r[4:2], 2'b00, r[1:0], 1'b1};
    wr(iep_pkg::A_EXFS, 8'hff);
    rd(iep_pkg::A_EXFS, e);
    wr(iep_pkg::A_EXFS, 8'h00);
    rd(iep_pkg::A_EXFS, e & 8'hfe);
    ext_flag <= '0;
    wr(iep_pkg::A_BEN, 8'h02);
    repeat (3) @(negedge clk);
    check({7'h0, irq_req}, 8'h00, "gated req");
    exp_vec.push_back(8'h01);
    wr(iep_pkg::A_BEN, 8'h82);
    drain();
    rd(iep_pkg::A_TPFC, 8'h00);
    $display("test flags done");
    wr(iep_pkg::A_BEN, 8'h8a);
    for (int i = 0; i < 2; i++) begin
      ack_dly <= 4'(rnd() & 8'h07);
      wr(iep_pkg::A_BPS, i ? 8'h00 : 8'h08);
      exp_vec.push_back(i ? 8'h01 : 8'h03);
      exp_vec.push_back(i ? 8'h03 : 8'h01);
      pulse(3'b011);
      drain();
    end
    pin_sel_one <= 8'h02;
    pin_rise_en <= 8'h03;
    pin_fall_en <= 8'h01;
    wr(iep_pkg::A_BEN, 8'h85);
    exp_vec.push_back(8'h00);
    exp_vec.push_back(8'h02);
    gpio_in <= 8'h03;
    drain();
    exp_vec.push_back(8'h00);
    gpio_in <= 8'h00;
    drain();
    rd(iep_pkg::A_TPFC, 8'h00);
    $display("test priority done");
    wr(iep_pkg::A_BEN, 8'h00);
    ack_dly <= 4'h3;
    exp_vec.push_back({3'h0, iep_pkg::V_DBG});
    exp_vec.push_back({3'h0, iep_pkg::V_BKP});
    dbg_req <= 1'b1;
    bkp_req <= 1'b1;
    wait_req(1'b1);
    dbg_req <= 1'b0;
    wait_req(1'b0);
    wait_req(1'b1);
    bkp_req <= 1'b0;
    drain();
    $display("test debug done");
    osc_running <= 1'(rnd() & 8'h01);
    wr(iep_pkg::A_WKM, 8'hfe);
    stop_mode <= 1'b1;
    wk(8'h01, 5'h00, 1'b0);
    wk(8'h03, 5'h00, 1'b1);
    wk(8'h03, 5'h10, 1'b1);
    wk(8'h03, 5'h14, 1'b0);
    wk(8'h03, 5'h15, 1'b0);
    stop_mode <= 1'b0;
    check(8'(exp_wk.size()), 8'h00, "wakes left");
    $display("test wake done");
    end_sim();
  end
endmodule
